// [core/test_io_defines.svh]
`ifndef TEST_IO_DEFINES_SVH
`define TEST_IO_DEFINES_SVH

// Register offsets
`define OFS_PIN_VALUE 6'h34
`define OFS_PROBE_BUS 6'h35
`define OFS_CHECK_CTRL 6'h36
`define OFS_REVISION 6'h37

// Field positions
`define BIT_PORT_IO_ENABLE 7
`define BIT_NONLINEAR_RX 6
`define BIT_DELIM_TRIM 5
`define KEY_MSB 3
`define SECURE_CLK_PIN 1

// Reset values and codes
`define RST_PIN_VALUE 8'h00
`define RST_CHECK_CTRL 8'h40
`define CHECK_CTRL_WMASK 8'h6F
`define SELFTEST_KEY_ON 4'h9
`define SELFTEST_KEY_OFF 4'h0

// Delimiter trim in carrier cycles
`define DELIM_TRIM_CYCLES 4'h8

`endif

// [core/test_io_pkg.sv]
package test_io_pkg;

	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	typedef struct packed {
		logic nonlinear_receive;
		logic frame_delimiter_trim;
		logic selftest_enable;
		logic [3:0] sof_high_extra;
		logic [3:0] sof_low_less;
		logic [3:0] eof_low_less;
		logic use_max_delimiter;
	} rx_tx_ctrl_s;

endpackage

// [core/test_io_selftest_regs.sv]
`timescale 1ns/1ps
`include "test_io_defines.svh"

module test_io_selftest_regs #(
	parameter logic [7:0] REVISION_CODE = 8'h5A, // Arbitrary value
	parameter int PINS = 7
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire test_io_pkg::reg_req_s req,
	output logic [7:0] rdata,
	input wire logic serial_host_active,
	input wire logic secure_clock_on_pin_one,
	input wire logic [PINS-1:0] port_drive_enable,
	input wire logic [7:0] probe_bus,
	input wire logic [PINS-1:0] pin_in,
	output logic [PINS-1:0] pin_out,
	output logic [PINS-1:0] pin_oe,
	output logic [PINS-1:0] pin_gpio_owned,
	output test_io_pkg::rx_tx_ctrl_s rx_tx_ctrl
);

	// --------------------------------------------------------------
	// Pin synchronisers
	// --------------------------------------------------------------
	logic [PINS-1:0] pin_meta_ff, pin_sync_ff;
	logic [PINS-1:0] nxt_pin_meta, nxt_pin_sync;

	always_comb begin
		nxt_pin_meta = pin_in;
		nxt_pin_sync = pin_meta_ff;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pin_meta_ff <= '0;
			pin_sync_ff <= '0;
		end else if (clk_en) begin
			pin_meta_ff <= nxt_pin_meta;
			pin_sync_ff <= nxt_pin_sync;
		end
	end

	// --------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------
	logic [7:0] pin_value_ff, check_ctrl_ff, rdata_ff;
	logic [7:0] nxt_pin_value, nxt_check_ctrl, nxt_rdata;
	logic io_mode;

	assign io_mode = pin_value_ff[`BIT_PORT_IO_ENABLE] & serial_host_active;

	always_comb begin
		nxt_pin_value = pin_value_ff;
		nxt_check_ctrl = check_ctrl_ff;
		nxt_rdata = 8'h00;
		if (req.wr) begin
			case (req.addr)
				`OFS_PIN_VALUE: nxt_pin_value = req.wdata;
				// Bit 7 and bit 4 are reserved and keep their value
				`OFS_CHECK_CTRL: nxt_check_ctrl = (check_ctrl_ff & ~`CHECK_CTRL_WMASK) |
					(req.wdata & `CHECK_CTRL_WMASK);
				default: nxt_pin_value = pin_value_ff;
			endcase
		end
		if (req.rd) begin
			case (req.addr)
				`OFS_PIN_VALUE: begin
					if (pin_value_ff[`BIT_PORT_IO_ENABLE])
						nxt_rdata = {1'b1, pin_sync_ff};
					else
						nxt_rdata = pin_value_ff;
				end
				`OFS_PROBE_BUS: nxt_rdata = probe_bus;
				`OFS_CHECK_CTRL: nxt_rdata = check_ctrl_ff;
				`OFS_REVISION: nxt_rdata = REVISION_CODE;
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pin_value_ff <= `RST_PIN_VALUE;
			check_ctrl_ff <= `RST_CHECK_CTRL;
			rdata_ff <= 8'h00;
		end else if (clk_en) begin
			pin_value_ff <= nxt_pin_value;
			check_ctrl_ff <= nxt_check_ctrl;
			rdata_ff <= nxt_rdata;
		end
	end

	assign rdata = rdata_ff;

	// --------------------------------------------------------------
	// Pin drivers
	// --------------------------------------------------------------
	// Outputs are combinational from flops so a drive enable change acts at once
	genvar gi;
	generate
		for (gi = 0; gi < PINS; gi++) begin : g_pin
			logic owned;
			if (gi == `SECURE_CLK_PIN) begin : g_d1
				assign owned = io_mode & ~secure_clock_on_pin_one;
			end else begin : g_dx
				assign owned = io_mode;
			end
			assign pin_gpio_owned[gi] = owned;
			assign pin_oe[gi] = owned & port_drive_enable[gi];
			assign pin_out[gi] = pin_oe[gi] & pin_value_ff[gi];
		end
	endgenerate

	// --------------------------------------------------------------
	// Receiver and framing controls
	// --------------------------------------------------------------
	logic trim_active;
	assign trim_active = check_ctrl_ff[`BIT_DELIM_TRIM];

	always_comb begin
		// Threshold logic downstream reads the same bit for its non-linear curve
		rx_tx_ctrl.nonlinear_receive = check_ctrl_ff[`BIT_NONLINEAR_RX];
		rx_tx_ctrl.frame_delimiter_trim = trim_active;
		rx_tx_ctrl.selftest_enable = (check_ctrl_ff[`KEY_MSB:0] == `SELFTEST_KEY_ON);
		rx_tx_ctrl.use_max_delimiter = 1'b1;
		rx_tx_ctrl.sof_high_extra = 4'h0;
		rx_tx_ctrl.sof_low_less = 4'h0;
		rx_tx_ctrl.eof_low_less = 4'h0;
		if (trim_active) begin
			rx_tx_ctrl.sof_high_extra = `DELIM_TRIM_CYCLES;
			rx_tx_ctrl.sof_low_less = `DELIM_TRIM_CYCLES;
			rx_tx_ctrl.eof_low_less = `DELIM_TRIM_CYCLES;
		end
	end

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	sequence s_rd_pin;
		req.rd && req.addr == `OFS_PIN_VALUE;
	endsequence

	property p_live_read;
		@(posedge clk_sys) disable iff (!rst_n)
		s_rd_pin and (clk_en && pin_value_ff[7]) |=> rdata[6:0] == $past(pin_sync_ff);
	endproperty
	a_live_read: assert property (p_live_read) else $error("live pin read wrong");

	property p_stored_read;
		@(posedge clk_sys) disable iff (!rst_n)
		s_rd_pin and (clk_en && !pin_value_ff[7]) |=> rdata == $past(pin_value_ff);
	endproperty
	a_stored_read: assert property (p_stored_read) else $error("stored pin read wrong");

	property p_no_drive_off;
		@(posedge clk_sys) disable iff (!rst_n)
		!(pin_value_ff[7] && serial_host_active) |-> pin_oe == '0;
	endproperty
	a_no_drive_off: assert property (p_no_drive_off) else $error("pin driven outside io mode");

	property p_dir;
		@(posedge clk_sys) disable iff (!rst_n)
		io_mode && !secure_clock_on_pin_one |-> pin_oe == port_drive_enable;
	endproperty
	a_dir: assert property (p_dir) else $error("pin direction wrong");

	property p_level;
		@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |-> (pin_out & pin_oe) == (pin_value_ff[6:0] & pin_oe);
	endproperty
	a_level: assert property (p_level) else $error("pin level wrong");

	property p_d1;
		@(posedge clk_sys) disable iff (!rst_n)
		secure_clock_on_pin_one |-> !pin_oe[1];
	endproperty
	a_d1: assert property (p_d1) else $error("D1 used while secure clock selected");

	property p_probe;
		@(posedge clk_sys) disable iff (!rst_n)
		req.rd && clk_en && req.addr == `OFS_PROBE_BUS |=> rdata == $past(probe_bus);
	endproperty
	a_probe: assert property (p_probe) else $error("probe read wrong");

	property p_key;
		@(posedge clk_sys) disable iff (!rst_n)
		rx_tx_ctrl.selftest_enable |-> check_ctrl_ff[3:0] == 4'h9;
	endproperty
	a_key: assert property (p_key) else $error("self-test key wrong");

	property p_ro_write;
		@(posedge clk_sys) disable iff (!rst_n)
		req.wr && req.addr != `OFS_PIN_VALUE && req.addr != `OFS_CHECK_CTRL |=> $stable(pin_value_ff)
			&& $stable(check_ctrl_ff);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only write took effect");

	property p_reset;
		@(posedge clk_sys) !rst_n |=> pin_value_ff == 8'h00 && check_ctrl_ff == 8'h40 && rdata == 8'h00;
	endproperty
	a_reset: assert property (p_reset) else $error("reset values wrong");

	// Reset is sampled inside these steps: disable iff alone sees the released level too early
	sequence s_wr_pin;
		rst_n && clk_en && req.wr && req.addr == `OFS_PIN_VALUE;
	endsequence

	sequence s_wr_ctrl;
		rst_n && clk_en && req.wr && req.addr == `OFS_CHECK_CTRL;
	endsequence

	sequence s_en_twice;
		(rst_n && clk_en) ##1 (rst_n && clk_en);
	endsequence

	property p_wr_pin;
		@(posedge clk_sys) disable iff (!rst_n)
		s_wr_pin |=> pin_value_ff == $past(req.wdata);
	endproperty
	a_wr_pin: assert property (p_wr_pin) else $error("pin value write lost");

	property p_wr_ctrl;
		@(posedge clk_sys) disable iff (!rst_n)
		s_wr_ctrl |=> check_ctrl_ff == (($past(check_ctrl_ff) & 8'h90) | ($past(req.wdata) & 8'h6F));
	endproperty
	a_wr_ctrl: assert property (p_wr_ctrl) else $error("control write wrong");

	property p_freeze;
		@(posedge clk_sys) disable iff (!rst_n)
		rst_n && !clk_en |=> $stable(pin_value_ff) && $stable(check_ctrl_ff) && $stable(rdata) && $stable(pin_sync_ff);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

	property p_rdata_idle;
		@(posedge clk_sys) disable iff (!rst_n)
		rst_n && clk_en && !(req.rd && req.addr >= `OFS_PIN_VALUE && req.addr <= `OFS_REVISION) |=> rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

	property p_rev;
		@(posedge clk_sys) disable iff (!rst_n)
		clk_en && req.rd && req.addr == `OFS_REVISION |=> rdata == REVISION_CODE;
	endproperty
	a_rev: assert property (p_rev) else $error("revision read wrong");

	property p_undriven;
		@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |-> (pin_out & ~pin_oe) == '0;
	endproperty
	a_undriven: assert property (p_undriven) else $error("undriven pin shows a level");

	property p_owned_off;
		@(posedge clk_sys) disable iff (!rst_n)
		!io_mode |-> pin_gpio_owned == '0;
	endproperty
	a_owned_off: assert property (p_owned_off) else $error("pin owned outside io mode");

	property p_sync;
		@(posedge clk_sys) disable iff (!rst_n)
		s_en_twice |=> pin_sync_ff == $past(pin_in, 2);
	endproperty
	a_sync: assert property (p_sync) else $error("pin synchroniser depth wrong");

	property p_nonlinear;
		@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |-> rx_tx_ctrl.nonlinear_receive == check_ctrl_ff[`BIT_NONLINEAR_RX];
	endproperty
	a_nonlinear: assert property (p_nonlinear) else $error("nonlinear receive wrong");

	property p_trim_on;
		@(posedge clk_sys) disable iff (!rst_n)
		check_ctrl_ff[`BIT_DELIM_TRIM] |-> rx_tx_ctrl.sof_high_extra == 4'h8 && rx_tx_ctrl.sof_low_less == 4'h8
			&& rx_tx_ctrl.eof_low_less == 4'h8;
	endproperty
	a_trim_on: assert property (p_trim_on) else $error("delimiter trim wrong");

	property p_trim_off;
		@(posedge clk_sys) disable iff (!rst_n)
		!check_ctrl_ff[`BIT_DELIM_TRIM] |-> {rx_tx_ctrl.sof_high_extra, rx_tx_ctrl.sof_low_less,
			rx_tx_ctrl.eof_low_less} == 12'h000 && rx_tx_ctrl.use_max_delimiter;
	endproperty
	a_trim_off: assert property (p_trim_off) else $error("untrimmed delimiter wrong");

	property p_key_off;
		@(posedge clk_sys) disable iff (!rst_n)
		check_ctrl_ff[3:0] != 4'h9 |-> !rx_tx_ctrl.selftest_enable;
	endproperty
	a_key_off: assert property (p_key_off) else $error("self-test enabled without key");

	property p_reserved;
		@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |-> check_ctrl_ff[7] == 1'b0 && check_ctrl_ff[4] == 1'b0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved control bit changed");

endmodule

// [testbench/test_test_io_selftest_regs.sv]
`timescale 1ns/1ps
module test_test_io_selftest_regs;
	localparam logic [7:0] REV = 8'hC3; // Arbitrary value
	logic clk_sys = 1'b0;
	logic rst_n, clk_en, serial_host_active, secure_clock_on_pin_one, pend;
	test_io_pkg::reg_req_s req;
	test_io_pkg::rx_tx_ctrl_s rx;
	logic [7:0] rdata, probe_bus, v, pb, en, d, sec;
	logic [6:0] port_drive_enable, pin_in, pin_out, pin_oe, own;
	logic [31:0] seed;
	logic [7:0] expq[$];
	logic [7:0] ctl[5];
	int bad_count, checks;

	test_io_selftest_regs #(.REVISION_CODE(REV), .PINS(7)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
		.clk_en(clk_en), .req(req), .rdata(rdata), .serial_host_active(serial_host_active),
		.secure_clock_on_pin_one(secure_clock_on_pin_one), .port_drive_enable(port_drive_enable),
		.probe_bus(probe_bus), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_gpio_owned(own), .rx_tx_ctrl(rx));

	always #4 clk_sys = ~clk_sys;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Idle cycle after each strobe keeps a strobe from being driven twice in one step
	task automatic wr(input logic [5:0] a, input logic [7:0] dat);
		req.addr <= a;
		req.wdata <= dat;
		req.wr <= 1'b1;
		@(posedge clk_sys);
		req.wr <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		expq.push_back(exp);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk_sys);
		req.rd <= 1'b0;
		@(posedge clk_sys);
	endtask

	// ------------------------------------------------------------
	// Read data monitor
	// ------------------------------------------------------------
	always @(posedge clk_sys) pend <= req.rd;
	always @(negedge clk_sys) if (pend) check(rdata, expq.pop_front());

	initial begin
		#(8 * 5000);
		bad_count++;
		tally_and_finish();
	end

	// ------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------
	initial begin
		rst_n = 0;
		clk_en = 1;
		req = '0;
		serial_host_active = 0;
		secure_clock_on_pin_one = 0;
		port_drive_enable = '0;
		probe_bus = '0;
		pin_in = '0;
		seed = 32'h00016DD1;
		ctl = '{8'hFF, 8'h49, 8'h29, 8'h00, 8'h00};
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rd(6'h34, 8'h00);
		rd(6'h36, 8'h40);
		rd(6'h37, REV);
		rd(6'h3F, 8'h00);
		for (int i = 0; i < 8; i++) begin
			v = rnd();
			pb = rnd();
			en = rnd();
			probe_bus <= pb;
			wr(6'h35, ~pb);
			wr(6'h37, ~REV);
			rd(6'h35, pb);
			rd(6'h37, REV);
			wr(6'h34, {1'b0, v[6:0]});
			rd(6'h34, {1'b0, v[6:0]});
			check({1'b0, pin_oe}, 8'h00);
			serial_host_active <= 1'b1;
			port_drive_enable <= en[6:0];
			pin_in <= pb[6:0];
			secure_clock_on_pin_one <= v[7];
			sec = v[7] ? 8'h02 : 8'h00;
			wr(6'h34, {1'b1, v[6:0]});
			@(negedge clk_sys);
			check({1'b0, pin_oe}, {1'b0, en[6:0]} & ~sec);
			check({1'b0, pin_out}, {1'b0, v[6:0] & en[6:0]} & ~sec);
			check({1'b0, own}, 8'h7F & ~sec);
			@(posedge clk_sys);
			rd(6'h34, {1'b1, pb[6:0]});
			serial_host_active <= 1'b0;
			@(posedge clk_sys);
			@(negedge clk_sys);
			check({1'b0, pin_oe}, 8'h00);
			@(posedge clk_sys);
			wr(6'h34, 8'h00);
		end
		ctl[4] = rnd();
		foreach (ctl[k]) begin
			d = ctl[k];
			wr(6'h36, d);
			rd(6'h36, d & 8'h6F);
			check({5'h0, rx.nonlinear_receive, rx.frame_delimiter_trim, rx.selftest_enable},
				{5'h0, d[6], d[5], d[3:0] == 4'h9});
			check({rx.sof_high_extra, rx.sof_low_less}, d[5] ? 8'h88 : 8'h00);
			check({rx.eof_low_less, 3'h0, rx.use_max_delimiter}, d[5] ? 8'h81 : 8'h01);
		end
		clk_en <= 1'b0;
		wr(6'h34, 8'h3C);
		clk_en <= 1'b1;
		rd(6'h34, 8'h00);
		wr(6'h34, 8'h5A);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rd(6'h34, 8'h00);
		rd(6'h36, 8'h40);
		repeat (2) @(posedge clk_sys);
		tally_and_finish();
	end
endmodule
